// ### lineif_pkg.sv
// Purpose: shared constants for the four-channel line control and alarm block
// Assumes: clk_sys at 40 MHz, register bus with 32-bit data
// Notes: offsets are byte addresses, one register per aligned word
package lineif_pkg;

    localparam int CH_N = 4;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int CLK_PERIOD_NS = 25;

    // register offsets
    localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
    localparam logic [ADDR_W-1:0] REG_INT_STAT = 8'h08;
    localparam logic [ADDR_W-1:0] REG_INT_MASK = 8'h0C;

    // control fields, one bit per channel
    localparam int CTRL_ONES_LSB = 0;
    localparam int CTRL_E3_LSB = 4;
    localparam int CTRL_STS1_LSB = 8;

    // status and interrupt fields, one bit per channel, except the single host mode status bit
    localparam int STAT_DRIVE_LSB = 0;
    localparam int STAT_LOS_LSB = 4;
    localparam int STAT_LOL_LSB = 8;
    localparam int STAT_HOST_BIT = 12;
    localparam int EVT_W = 12;

    // reset values
    localparam logic [DATA_W-1:0] CTRL_RST = 32'h0000_0000;
    localparam logic [EVT_W-1:0] INT_MASK_RST = 12'h000;

    // drive monitor: transmit clock periods without a mark
    localparam int DRIVE_MON_PERIODS = 128;
    localparam int DRIVE_MON_TOL = 32;
    localparam int DRIVE_CNT_W = 8;

    // lock check: reference window and tolerance in parts per thousand
    localparam int LOL_WINDOW = 1024;
    localparam int LOL_TOL_PERMILLE = 5;
    localparam int LOL_TOL_COUNT = LOL_WINDOW * LOL_TOL_PERMILLE / 1000;
    localparam int LOL_CNT_W = 12;

    // signal loss: clk_sys cycles without a received mark, per rate
    localparam int LOS_E3_CYCLES = 400;
    localparam int LOS_DS3_CYCLES = 700;
    localparam int LOS_CNT_W = 12;

    typedef enum logic [1:0] {
        RATE_DS3 = 2'b00,
        RATE_STS1 = 2'b01,
        RATE_E3 = 2'b10
    } rate_t;

endpackage

// ### lineif_lock_check.sv
// Purpose: one channel's loss-of-lock detector
// Assumes: both clock levels sampled as synchronous inputs of clk_sys
// Notes: counts recovered edges across a fixed window of reference edges
`timescale 1ns/1ps
module lineif_lock_check
    import lineif_pkg::*;
#(
    parameter int WINDOW = LOL_WINDOW,
    parameter int TOL = LOL_TOL_COUNT
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic refClock,
    input wire logic recClock,
    output logic lockLoss
);

    logic refPrev_ff, nxt_refPrev;
    logic recPrev_ff, nxt_recPrev;
    logic [LOL_CNT_W-1:0] refCnt_ff, nxt_refCnt;
    logic [LOL_CNT_W-1:0] recCnt_ff, nxt_recCnt;
    logic lockLoss_ff, nxt_lockLoss;
    logic refEdge, recEdge;
    logic [LOL_CNT_W-1:0] recTotal, diff;

    // window counters and verdict at window close
    always_comb begin
        refEdge = refClock & ~refPrev_ff;
        recEdge = recClock & ~recPrev_ff;
        nxt_refPrev = refClock;
        nxt_recPrev = recClock;
        nxt_lockLoss = lockLoss_ff;
        recTotal = recCnt_ff + LOL_CNT_W'(recEdge);
        if (recTotal > LOL_CNT_W'(WINDOW)) begin
            diff = recTotal - LOL_CNT_W'(WINDOW);
        end else begin
            diff = LOL_CNT_W'(WINDOW) - recTotal;
        end
        nxt_refCnt = refCnt_ff + LOL_CNT_W'(refEdge);
        nxt_recCnt = recTotal;
        if (refEdge && refCnt_ff == LOL_CNT_W'(WINDOW - 1)) begin
            nxt_lockLoss = (diff > LOL_CNT_W'(TOL));
            nxt_refCnt = '0;
            nxt_recCnt = '0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            refPrev_ff <= 1'b0;
            recPrev_ff <= 1'b0;
            refCnt_ff <= '0;
            recCnt_ff <= '0;
            lockLoss_ff <= 1'b0;
        end else begin
            refPrev_ff <= nxt_refPrev;
            recPrev_ff <= nxt_recPrev;
            refCnt_ff <= nxt_refCnt;
            recCnt_ff <= nxt_recCnt;
            lockLoss_ff <= nxt_lockLoss;
        end
    end

    assign lockLoss = lockLoss_ff;

endmodule // lineif_lock_check

// ### lineif_mode_alarm_ctrl.sv
// Purpose: mode select, drive monitor, forced ones and receive alarms, four channels
// Assumes: all pins synchronous to clk_sys; clocks arrive as sampled levels
// Notes: registers on a plain strobe port, read data one cycle after the strobe
//
// Our own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
module lineif_mode_alarm_ctrl
    import lineif_pkg::*;
#(
    parameter int CHANNELS = CH_N,
    parameter int DRIVE_LIMIT = DRIVE_MON_PERIODS,
    parameter int LOS_E3_LIMIT = LOS_E3_CYCLES,
    parameter int LOS_DS3_LIMIT = LOS_DS3_CYCLES
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic cfgSourceSelect,
    output logic serialIfEnable,
    input wire logic [CHANNELS-1:0] txClock,
    input wire logic [CHANNELS-1:0] referenceClock,
    input wire logic [CHANNELS-1:0] recoveredClock,
    input wire logic [CHANNELS-1:0] txDataPos,
    input wire logic [CHANNELS-1:0] txDataNeg,
    input wire logic [CHANNELS-1:0] rxMarkPos,
    input wire logic [CHANNELS-1:0] rxMarkNeg,
    input wire logic [CHANNELS-1:0] monitorTipIn,
    input wire logic [CHANNELS-1:0] monitorRingIn,
    input wire logic [CHANNELS-1:0] forceOnesSelect,
    input wire logic [CHANNELS-1:0] e3RateSelect,
    input wire logic [CHANNELS-1:0] sts1Ds3RateSelect,
    output logic [CHANNELS-1:0] lineOutTip,
    output logic [CHANNELS-1:0] lineOutRing,
    output logic [CHANNELS-1:0] driveFailFlag,
    output logic [CHANNELS-1:0] rxSignalLossFlag,
    output logic [CHANNELS-1:0] rxLockLossFlag,
    output logic [2*CHANNELS-1:0] rateMode,
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [DATA_W-1:0] regWrData,
    input wire logic regWrEn,
    input wire logic regRdEn,
    output logic [DATA_W-1:0] regRdData,
    output logic irq
);

    // register state
    logic [DATA_W-1:0] ctrl_ff, nxt_ctrl;
    logic [EVT_W-1:0] intStat_ff, nxt_intStat;
    logic [EVT_W-1:0] intMask_ff, nxt_intMask;
    logic [DATA_W-1:0] rdData_ff, nxt_rdData;

    // channel state
    logic [CHANNELS-1:0] txPrev_ff, nxt_txPrev;
    logic [CHANNELS-1:0] onesPol_ff, nxt_onesPol;
    logic [CHANNELS-1:0] tip_ff, nxt_tip;
    logic [CHANNELS-1:0] ring_ff, nxt_ring;
    logic [CHANNELS-1:0] drive_ff, nxt_drive;
    logic [CHANNELS-1:0] los_ff, nxt_los;
    logic [DRIVE_CNT_W-1:0] driveCnt_ff [CHANNELS];
    logic [DRIVE_CNT_W-1:0] nxt_driveCnt [CHANNELS];
    logic [LOS_CNT_W-1:0] losCnt_ff [CHANNELS];
    logic [LOS_CNT_W-1:0] nxt_losCnt [CHANNELS];
    logic [CHANNELS-1:0] lockLoss;
    logic [CHANNELS-1:0] txEdge;
    logic [CHANNELS-1:0] monMark;
    logic [CHANNELS-1:0] rxMark;
    logic [EVT_W-1:0] flagsNow_ff, nxt_flagsNow;

    // effective configuration
    logic hostMode;
    logic [CHANNELS-1:0] onesEff, e3Eff, sts1Eff;
    rate_t rate [CHANNELS];

    // mode select and per-channel rate
    always_comb begin
        hostMode = cfgSourceSelect;
        for (int i = 0; i < CHANNELS; i++) begin
            if (hostMode) begin
                onesEff[i] = ctrl_ff[CTRL_ONES_LSB + i];
                e3Eff[i] = ctrl_ff[CTRL_E3_LSB + i];
                sts1Eff[i] = ctrl_ff[CTRL_STS1_LSB + i];
            end else begin
                onesEff[i] = forceOnesSelect[i];
                e3Eff[i] = e3RateSelect[i];
                sts1Eff[i] = sts1Ds3RateSelect[i];
            end
            if (e3Eff[i]) begin
                rate[i] = RATE_E3;
            end else if (sts1Eff[i]) begin
                rate[i] = RATE_STS1;
            end else begin
                rate[i] = RATE_DS3;
            end
            rateMode[2*i +: 2] = rate[i];
        end
    end

    assign serialIfEnable = hostMode;

    // sampled clock rising edges, one per channel
    assign txEdge = txClock & ~txPrev_ff;

    // a mark on either monitor tap proves the driver works
    assign monMark = monitorTipIn | monitorRingIn;

    // a received mark on either rail
    assign rxMark = rxMarkPos | rxMarkNeg;

    // line marks: forced alternating marks or user data
    // polarity starts low, so the first forced mark goes out on ring
    always_comb begin
        nxt_txPrev = txClock;
        nxt_onesPol = onesPol_ff;
        nxt_tip = tip_ff;
        nxt_ring = ring_ff;
        for (int i = 0; i < CHANNELS; i++) begin
            if (txEdge[i]) begin
                if (onesEff[i]) begin
                    nxt_tip[i] = onesPol_ff[i];
                    nxt_ring[i] = ~onesPol_ff[i];
                    nxt_onesPol[i] = ~onesPol_ff[i];
                end else begin
                    nxt_tip[i] = txDataPos[i];
                    nxt_ring[i] = txDataNeg[i];
                end
            end
        end
    end

    // line mark registers
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            txPrev_ff <= '0;
            onesPol_ff <= '0;
            tip_ff <= '0;
            ring_ff <= '0;
        end else begin
            txPrev_ff <= nxt_txPrev;
            onesPol_ff <= nxt_onesPol;
            tip_ff <= nxt_tip;
            ring_ff <= nxt_ring;
        end
    end

    // drive monitor, any monitor mark restarts the count
    // count saturates at the limit so the flag cannot wrap back low
    always_comb begin
        nxt_drive = drive_ff;
        for (int i = 0; i < CHANNELS; i++) begin
            nxt_driveCnt[i] = driveCnt_ff[i];
            if (txEdge[i] && driveCnt_ff[i] < DRIVE_CNT_W'(DRIVE_LIMIT)) begin
                nxt_driveCnt[i] = driveCnt_ff[i] + 1'b1;
            end
            if (driveCnt_ff[i] >= DRIVE_CNT_W'(DRIVE_LIMIT)) begin
                nxt_drive[i] = 1'b1;
            end
            if (monMark[i]) begin
                nxt_driveCnt[i] = '0;
                nxt_drive[i] = 1'b0;
            end
        end
    end

    // drive monitor registers
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            drive_ff <= '0;
            for (int i = 0; i < CHANNELS; i++) begin
                driveCnt_ff[i] <= '0;
            end
        end else begin
            drive_ff <= nxt_drive;
            for (int i = 0; i < CHANNELS; i++) begin
                driveCnt_ff[i] <= nxt_driveCnt[i];
            end
        end
    end

    // signal loss: quiet cycles against the limit of the rate
    // counter saturates at all ones; a mark clears the flag next edge
    always_comb begin
        nxt_los = los_ff;
        for (int i = 0; i < CHANNELS; i++) begin
            nxt_losCnt[i] = losCnt_ff[i];
            if (rxMark[i]) begin
                nxt_losCnt[i] = '0;
                nxt_los[i] = 1'b0;
            end else begin
                if (losCnt_ff[i] != '1) begin
                    nxt_losCnt[i] = losCnt_ff[i] + 1'b1;
                end
                if (rate[i] == RATE_E3) begin
                    nxt_los[i] = los_ff[i] | (losCnt_ff[i] >= LOS_CNT_W'(LOS_E3_LIMIT));
                end else begin
                    nxt_los[i] = los_ff[i] | (losCnt_ff[i] >= LOS_CNT_W'(LOS_DS3_LIMIT));
                end
            end
        end
    end

    // signal loss registers
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            los_ff <= '0;
            for (int i = 0; i < CHANNELS; i++) begin
                losCnt_ff[i] <= '0;
            end
        end else begin
            los_ff <= nxt_los;
            for (int i = 0; i < CHANNELS; i++) begin
                losCnt_ff[i] <= nxt_losCnt[i];
            end
        end
    end

    // one lock checker per channel
    genvar g;
    generate
        for (g = 0; g < CHANNELS; g++) begin : gen_lock
            lineif_lock_check u_lock (
                .clk_sys(clk_sys),
                .sys_rst(sys_rst),
                .refClock(referenceClock[g]),
                .recClock(recoveredClock[g]),
                .lockLoss(lockLoss[g])
            );
        end
    endgenerate

    assign lineOutTip = tip_ff;
    assign lineOutRing = ring_ff;
    assign driveFailFlag = drive_ff;
    assign rxSignalLossFlag = los_ff;
    assign rxLockLossFlag = lockLoss;

    // register writes, sticky events with set winning over clear
    always_comb begin
        nxt_ctrl = ctrl_ff;
        nxt_intMask = intMask_ff;
        nxt_flagsNow = '0;
        nxt_flagsNow[STAT_DRIVE_LSB +: CH_N] = drive_ff[CH_N-1:0];
        nxt_flagsNow[STAT_LOS_LSB +: CH_N] = los_ff[CH_N-1:0];
        nxt_flagsNow[STAT_LOL_LSB +: CH_N] = lockLoss[CH_N-1:0];
        nxt_intStat = intStat_ff;
        if (regWrEn) begin
            if (regAddr == REG_CTRL) begin
                nxt_ctrl = regWrData;
            end
            if (regAddr == REG_INT_MASK) begin
                nxt_intMask = regWrData[EVT_W-1:0];
            end
            if (regAddr == REG_INT_STAT) begin
                nxt_intStat = intStat_ff & ~regWrData[EVT_W-1:0];
            end
        end
        nxt_intStat = nxt_intStat | (nxt_flagsNow & ~flagsNow_ff);
    end

    // register reads, answered in the next cycle
    always_comb begin
        nxt_rdData = '0;
        if (regRdEn) begin
            unique case (regAddr)
                REG_CTRL: nxt_rdData = ctrl_ff;
                REG_STATUS: begin
                    nxt_rdData[EVT_W-1:0] = flagsNow_ff;
                    nxt_rdData[STAT_HOST_BIT] = hostMode;
                end
                REG_INT_STAT: nxt_rdData[EVT_W-1:0] = intStat_ff;
                REG_INT_MASK: nxt_rdData[EVT_W-1:0] = intMask_ff;
                default: nxt_rdData = '0; // unmapped reads as zero
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            ctrl_ff <= CTRL_RST;
            intStat_ff <= '0;
            intMask_ff <= INT_MASK_RST;
            rdData_ff <= '0;
            flagsNow_ff <= '0;
        end else begin
            ctrl_ff <= nxt_ctrl;
            intStat_ff <= nxt_intStat;
            intMask_ff <= nxt_intMask;
            rdData_ff <= nxt_rdData;
            flagsNow_ff <= nxt_flagsNow;
        end
    end

    assign regRdData = rdData_ff;
    assign irq = |(intStat_ff & intMask_ff); // level interrupt

endmodule // lineif_mode_alarm_ctrl

// ### lineif_line_model.sv
// Purpose: line side model: line clocks, monitor taps, receive marks
// Assumes: clocks made by dividing clk_sys
// Notes: taps mirror the line while tapOn is high
`timescale 1ns/1ps
module lineif_line_model (
    input wire logic clk_sys,
    input wire logic tapOn,
    input wire logic rxOn,
    input wire logic slip,
    input wire logic [3:0] lineOutTip,
    input wire logic [3:0] lineOutRing,
    output logic [3:0] txClock,
    output logic [3:0] referenceClock,
    output logic [3:0] recoveredClock,
    output logic [3:0] monitorTipIn,
    output logic [3:0] monitorRingIn,
    output logic [3:0] rxMarkPos,
    output logic [3:0] rxMarkNeg
);
    logic [2:0] div_ff = 3'h0;
    logic [2:0] nxt_div;
    // tx clock period 8, reference period 4; slip stops recovery
    always_comb begin
        nxt_div = div_ff + 3'h1;
        txClock = {4{div_ff[2]}};
        referenceClock = {4{div_ff[1]}};
        recoveredClock = slip ? 4'h0 : referenceClock;
        monitorTipIn = tapOn ? lineOutTip : 4'h0;
        monitorRingIn = tapOn ? lineOutRing : 4'h0;
        rxMarkPos = rxOn ? referenceClock : 4'h0;
        rxMarkNeg = rxOn ? ~referenceClock : 4'h0;
    end
    // divider register
    always_ff @(posedge clk_sys) begin
        div_ff <= nxt_div;
    end
endmodule // lineif_line_model

// ### lineif_mode_alarm_ctrl_properties.sv
// Purpose: port checks of the mode and alarm block
// Assumes: channel 0 stands for all channels
// Notes: bound into every instance
`timescale 1ns/1ps
module lineif_alarm_checker
    import lineif_pkg::*;
#(
    parameter int DRIVE_LIMIT = DRIVE_MON_PERIODS,
    parameter int LOS_E3_LIMIT = LOS_E3_CYCLES,
    parameter int LOS_DS3_LIMIT = LOS_DS3_CYCLES
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic cfgSourceSelect,
    input wire logic serialIfEnable,
    input wire logic [3:0] txClock,
    input wire logic [3:0] monitorTipIn,
    input wire logic [3:0] monitorRingIn,
    input wire logic [3:0] rxMarkPos,
    input wire logic [3:0] rxMarkNeg,
    input wire logic [3:0] forceOnesSelect,
    input wire logic [3:0] e3RateSelect,
    input wire logic [3:0] sts1Ds3RateSelect,
    input wire logic [3:0] lineOutTip,
    input wire logic [3:0] lineOutRing,
    input wire logic [3:0] driveFailFlag,
    input wire logic [3:0] rxSignalLossFlag,
    input wire logic [7:0] rateMode
);
    logic txPrev_ff, nxt_txPrev, mk;
    logic [7:0] txQuiet_ff, nxt_txQuiet;
    logic [11:0] rxQuiet_ff, nxt_rxQuiet;
    int losLim;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    // quiet spans on channel 0 since its last mark
    always_comb begin
        mk = monitorTipIn[0] | monitorRingIn[0];
        nxt_txPrev = txClock[0];
        nxt_txQuiet = mk ? 8'h00 : txQuiet_ff + 8'(txClock[0] & ~txPrev_ff);
        nxt_rxQuiet = (rxMarkPos[0] | rxMarkNeg[0]) ? 12'h000 : rxQuiet_ff + 12'h001;
        losLim = (rateMode[1:0] == RATE_E3) ? LOS_E3_LIMIT : LOS_DS3_LIMIT;
    end
    // counter registers
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            txQuiet_ff <= 8'h00;
            rxQuiet_ff <= 12'h000;
        end else begin
            txQuiet_ff <= nxt_txQuiet;
            rxQuiet_ff <= nxt_rxQuiet;
        end
        txPrev_ff <= nxt_txPrev;
    end
    property p_host;
        serialIfEnable == cfgSourceSelect;
    endproperty
    a_host: assert property (p_host) else $error("serial enable wrong");
    property p_rate;
        !cfgSourceSelect |-> rateMode[1:0] ==
            (e3RateSelect[0] ? 2'b10 : {1'b0, sts1Ds3RateSelect[0]});
    endproperty
    a_rate: assert property (p_rate) else $error("pin rate wrong");
    property p_drv_rise;
        $rose(driveFailFlag[0]) |-> txQuiet_ff >= DRIVE_LIMIT && txQuiet_ff <= DRIVE_LIMIT + 1;
    endproperty
    a_drv_rise: assert property (p_drv_rise) else $error("drive flag early");
    property p_drv_hold;
        driveFailFlag[0] && !mk |=> driveFailFlag[0];
    endproperty
    a_drv_hold: assert property (p_drv_hold) else $error("drive flag dropped");
    property p_drv_clr;
        mk |=> !driveFailFlag[0];
    endproperty
    a_drv_clr: assert property (p_drv_clr) else $error("drive flag stuck");
    property p_los_rise;
        $rose(rxSignalLossFlag[0]) |-> rxQuiet_ff + 1 >= losLim && rxQuiet_ff <= losLim + 2;
    endproperty
    a_los_rise: assert property (p_los_rise) else $error("loss flag timing");
    property p_los_clr;
        rxMarkPos[0] | rxMarkNeg[0] |=> !rxSignalLossFlag[0];
    endproperty
    a_los_clr: assert property (p_los_clr) else $error("loss flag stuck");
    property p_ones;
        (!cfgSourceSelect && forceOnesSelect[0])[*3] ##0 $rose(txClock[0])
            |-> ##3 (lineOutTip[0] ^ lineOutRing[0]);
    endproperty
    a_ones: assert property (p_ones) else $error("no forced mark");
endmodule // lineif_alarm_checker

bind lineif_mode_alarm_ctrl lineif_alarm_checker #(.DRIVE_LIMIT(DRIVE_LIMIT),
    .LOS_E3_LIMIT(LOS_E3_LIMIT), .LOS_DS3_LIMIT(LOS_DS3_LIMIT)) chk_i (.*);

// ### tb_lineif_mode_alarm_ctrl.sv
// Purpose: self-checking bench of the mode and alarm block
// Assumes: short drive and signal loss limits
// Notes: line side comes from lineif_line_model
`timescale 1ns/1ps
module tb_lineif_mode_alarm_ctrl;
    import lineif_pkg::*;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic cfgSourceSelect = 1'b0;
    logic tapOn = 1'b1;
    logic rxOn = 1'b1;
    logic slip = 1'b0;
    logic regWrEn = 1'b0;
    logic regRdEn = 1'b0;
    logic serialIfEnable, irq;
    logic [7:0] regAddr = 8'h00;
    logic [31:0] regWrData = 32'h0000_0000;
    logic [31:0] regRdData;
    logic [3:0] forceOnesSelect = 4'h0, e3RateSelect = 4'h0, sts1Ds3RateSelect = 4'h0;
    logic [3:0] txDataPos = 4'hF, txDataNeg = 4'h0;
    logic [3:0] txClock, referenceClock, recoveredClock, monitorTipIn, monitorRingIn;
    logic [3:0] rxMarkPos, rxMarkNeg, lineOutTip, lineOutRing;
    logic [3:0] driveFailFlag, rxSignalLossFlag, rxLockLossFlag;
    logic [7:0] rateMode;
    int failures = 0;
    int checks_done = 0;
    // 40 MHz clock
    always #12.5 clk_sys = ~clk_sys;
    lineif_mode_alarm_ctrl #(.DRIVE_LIMIT(8), .LOS_E3_LIMIT(20), .LOS_DS3_LIMIT(30)) uut (.*);
    lineif_line_model lineSide (.*);
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            failures++;
            $display("unexpected %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        cyc(1);
        regAddr <= a;
        regWrData <= d;
        regWrEn <= 1'b1;
        cyc(1);
        regWrEn <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
        cyc(1);
        regAddr <= a;
        regRdEn <= 1'b1;
        cyc(1);
        regRdEn <= 1'b0;
        #1 chk(n, e, regRdData);
    endtask
    task automatic t_mode();
        rd(REG_INT_MASK, 32'(INT_MASK_RST), "mask");
        rd(8'h40, 32'h0000_0000, "unmapped");
        for (int m = 0; m < 4; m++) begin
            cyc(1);
            e3RateSelect <= {4{m[1]}};
            sts1Ds3RateSelect <= {4{m[0]}};
            #1 chk("rate", {4{m[1] ? 2'b10 : {1'b0, m[0]}}}, rateMode);
        end
        cyc(1);
        cfgSourceSelect <= 1'b1;
        #1 chk("serial", 1, serialIfEnable);
        chk("rate", 0, rateMode);
        wr(REG_CTRL, 32'h0000_0360);
        cyc(1);
        #1 chk("rate", 8'h29, rateMode);
        rd(REG_STATUS, 32'h0000_1000, "status");
        cyc(1);
        cfgSourceSelect <= 1'b0;
        #1 chk("serial", 0, serialIfEnable);
        chk("rate", 8'hAA, rateMode);
    endtask
    task automatic t_drive();
        cyc(1);
        tapOn <= 1'b0;
        cyc(48);
        #1 chk("drive", 0, driveFailFlag);
        cyc(40);
        #1 chk("drive", 4'hF, driveFailFlag);
        cyc(1);
        tapOn <= 1'b1;
        cyc(2);
        #1 chk("drive", 0, driveFailFlag);
    endtask
    task automatic t_ones();
        logic [3:0] tip;
        cyc(1);
        txDataPos <= 4'h0;
        forceOnesSelect <= 4'hF;
        cyc(20);
        #1 chk("ones", 4'hF, lineOutTip ^ lineOutRing);
        tip = lineOutTip;
        cyc(8);
        #1 chk("ones", 4'(~tip), lineOutTip);
        cyc(1);
        cfgSourceSelect <= 1'b1;
        wr(REG_CTRL, 32'h0000_0000);
        cyc(20);
        #1 chk("ones", 0, lineOutTip | lineOutRing);
        wr(REG_CTRL, 32'h0000_0005);
        cyc(20);
        #1 chk("ones", 4'h5, lineOutTip ^ lineOutRing);
        cyc(1);
        cfgSourceSelect <= 1'b0;
        forceOnesSelect <= 4'h0;
        txDataPos <= 4'hF;
    endtask
    task automatic t_los();
        wr(REG_INT_STAT, 32'h0000_0FFF);
        cyc(1);
        e3RateSelect <= 4'h1;
        sts1Ds3RateSelect <= 4'h2;
        rxOn <= 1'b0;
        cyc(24);
        #1 chk("loss", 4'h1, rxSignalLossFlag);
        cyc(12);
        #1 chk("loss", 4'hF, rxSignalLossFlag);
        rd(REG_INT_STAT, 32'h0000_00F0, "events");
        chk("irq", 0, irq);
        wr(REG_INT_MASK, 32'h0000_00F0);
        cyc(1);
        #1 chk("irq", 1, irq);
        wr(REG_INT_STAT, 32'h0000_00F0);
        cyc(1);
        #1 chk("irq", 0, irq);
        rd(REG_STATUS, 32'h0000_00F0, "status");
        cyc(1);
        rxOn <= 1'b1;
        cyc(3);
        #1 chk("loss", 0, rxSignalLossFlag);
    endtask
    task automatic t_lock();
        cyc(4200);
        #1 chk("lock", 0, rxLockLossFlag);
        cyc(1);
        slip <= 1'b1;
        cyc(8400);
        #1 chk("lock", 4'hF, rxLockLossFlag);
        cyc(1);
        slip <= 1'b0;
        cyc(8400);
        #1 chk("lock", 0, rxLockLossFlag);
    endtask
    task automatic conclude();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // watchdog
    initial begin
        cyc(30000);
        failures++;
        conclude();
    end
    // main sequence
    initial begin
        cyc(10);
        sys_rst <= 1'b0;
        t_mode();
        t_drive();
        t_ones();
        t_los();
        t_lock();
        conclude();
    end
endmodule // tb_lineif_mode_alarm_ctrl
